/* inc/spi_nv_defs.svh */
// constants of the serial nonvolatile memory command engine
`ifndef SPI_NV_DEFS_SVH
`define SPI_NV_DEFS_SVH
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLR 8'h04
`define OP_STAT_RD 8'h05
`define OP_STAT_WR 8'h01
`define OP_MEM_RD 8'h03
`define OP_MEM_WR 8'h02
`define OP_ID_RD 8'h9f
`define OP_SLEEP 8'hb9
`define CLK_PERIOD_NS 10
`define WAKE_REC_US 400
`define ADDR_W 15
`define MEM_WORDS 32768
`define STAT_NV_RST 6'h00
`define STAT_PEN_BIT 5
`define BYTE_LAST 3'h7
`define ADDR_LAST 6'h0f
`define ID_LAST 6'h1f
`define ID_DONE 6'h20
`define PROT_QUARTER 2'h3
`endif

/* inc/spi_nv_pkg.sv */
// types of the serial nonvolatile memory command engine
package spi_nv_pkg;
    typedef enum logic [10:0] {
        ST_CMD = 11'h001,
        ST_ADDR = 11'h002,
        ST_STATUS_READ_CMD = 11'h004,
        ST_STATUS_WRITE_CMD = 11'h008,
        ST_READ = 11'h010,
        ST_WRITE = 11'h020,
        ST_IDENT_READ_CMD = 11'h040,
        ST_ARM = 11'h080,
        ST_IGN = 11'h100,
        ST_SLEEP = 11'h200,
        ST_WAKE = 11'h400
    } state_e;
endpackage

/* logic/spi_nv_mem.sv */
// serial nonvolatile memory: command engine, status and array
`timescale 1ns/10ps
`include "spi_nv_defs.svh"
module spi_nv_mem import spi_nv_pkg::*; #(
    parameter int unsigned WAKE_CYCLES =
        `WAKE_REC_US * 1000 / `CLK_PERIOD_NS,
    // identifier bytes: arbitrary values
    parameter logic [7:0] ID_MAKER = 8'h5a,
    parameter logic [7:0] ID_CONT = 8'h7f,
    parameter logic [7:0] ID_PROD0 = 8'h12,
    parameter logic [7:0] ID_PROD1 = 8'h34
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_hold_n,
    input wire logic i_wp_n,
    output logic o_so,
    output logic o_so_oe,
    output logic o_sleep,
    output logic [7:0] o_status
);
    logic [7:0] mem [`MEM_WORDS];
    logic [4:0] sy1_q, sy2_q;
    logic sck_prev_q, cs_prev_q;
    state_e st_q, st_d;
    logic [5:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, out_q, out_d;
    logic [`ADDR_W-1:0] addr_q, addr_d;
    logic so_q, so_d, oe_q, oe_d;
    logic wel_q, wel_d, clrw_q, clrw_d, wr_q, wr_d;
    logic [5:0] stat_q, stat_d;
    logic [15:0] wake_q, wake_d;
    logic mem_we;
    logic [7:0] op_in, stat_byte;
    logic cs_low, hold_act, rise, fall, cs_rise, cs_fall, wp_n_s;
    logic [`ADDR_W-1:0] addr_in;

    function automatic logic [7:0] id_byte(input logic [1:0] idx);
        case (idx)
            2'h0: id_byte = ID_MAKER;
            2'h1: id_byte = ID_CONT;
            2'h2: id_byte = ID_PROD0;
            default: id_byte = ID_PROD1;
        endcase
    endfunction

    function automatic logic is_prot(input logic [1:0] bp,
                                     input logic [`ADDR_W-1:0] a);
        case (bp)
            2'h0: is_prot = 1'b0;
            2'h1: is_prot = (a[14:13] == `PROT_QUARTER);
            2'h2: is_prot = a[14];
            default: is_prot = 1'b1;
        endcase
    endfunction

    // two-flop synchronisers for cs, sck, si, hold, wp
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sy1_q <= 5'h13;
            sy2_q <= 5'h13;
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sy1_q <= {i_cs_n, i_sck, i_si, i_hold_n, i_wp_n};
            sy2_q <= sy1_q;
            sck_prev_q <= sy2_q[3];
            cs_prev_q <= sy2_q[4];
        end
    end

    always_comb begin
        cs_low = ~sy2_q[4];
        wp_n_s = sy2_q[0];
        hold_act = cs_low & ~sy2_q[1];
        rise = sy2_q[3] & ~sck_prev_q & cs_low & ~hold_act;
        fall = ~sy2_q[3] & sck_prev_q & cs_low & ~hold_act;
        cs_rise = sy2_q[4] & ~cs_prev_q;
        cs_fall = ~sy2_q[4] & cs_prev_q;
        op_in = {sh_q[6:0], sy2_q[2]};
        addr_in = {addr_q[13:0], sy2_q[2]};
        stat_byte = {stat_q, wel_q, 1'b0};
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        out_d = out_q;
        so_d = so_q;
        addr_d = addr_q;
        wel_d = wel_q;
        clrw_d = clrw_q;
        wr_d = wr_q;
        stat_d = stat_q;
        wake_d = wake_q;
        mem_we = 1'b0;
        case (st_q)
            ST_SLEEP: begin
                if (cs_fall) begin
                    st_d = ST_WAKE;
                    wake_d = 16'h0000;
                end
            end
            ST_WAKE: begin
                if (wake_q == 16'(WAKE_CYCLES - 1)) begin
                    st_d = ST_CMD;
                    wel_d = 1'b0;
                    cnt_d = 6'h00;
                end else begin
                    wake_d = wake_q + 16'h0001;
                end
            end
            default: begin
                if (cs_rise) begin
                    // an unrecognised opcode leaves the latch alone
                    st_d = (st_q == ST_ARM) ? ST_SLEEP : ST_CMD;
                    cnt_d = 6'h00;
                    if (clrw_q) begin
                        wel_d = 1'b0;
                    end
                    clrw_d = 1'b0;
                end else if (fall) begin
                    if (!(st_q == ST_IDENT_READ_CMD && cnt_q == `ID_DONE)) begin
                        so_d = out_q[7];
                        out_d = {out_q[6:0], 1'b0};
                    end
                end else if (rise) begin
                    sh_d = op_in;
                    cnt_d = cnt_q + 6'h01;
                    case (st_q)
                        ST_CMD: begin
                            if (cnt_q[2:0] == `BYTE_LAST) begin
                                cnt_d = 6'h00;
                                st_d = ST_IGN;
                                case (op_in)
                                    `OP_LATCH_SET: wel_d = 1'b1;
                                    `OP_LATCH_CLR: wel_d = 1'b0;
                                    `OP_STAT_RD: begin
                                        st_d = ST_STATUS_READ_CMD;
                                        out_d = stat_byte;
                                    end
                                    `OP_STAT_WR: begin
                                        st_d = ST_STATUS_WRITE_CMD;
                                        clrw_d = 1'b1;
                                    end
                                    `OP_MEM_RD: begin
                                        st_d = ST_ADDR;
                                        wr_d = 1'b0;
                                    end
                                    `OP_MEM_WR: begin
                                        st_d = ST_ADDR;
                                        wr_d = 1'b1;
                                        clrw_d = 1'b1;
                                    end
                                    `OP_ID_RD: begin
                                        st_d = ST_IDENT_READ_CMD;
                                        out_d = id_byte(2'h0);
                                    end
                                    `OP_SLEEP: st_d = ST_ARM;
                                    default: st_d = ST_IGN;
                                endcase
                            end
                        end
                        ST_ADDR: begin
                            addr_d = addr_in;
                            if (cnt_q == `ADDR_LAST) begin
                                cnt_d = 6'h00;
                                st_d = wr_q ? ST_WRITE : ST_READ;
                                out_d = mem[addr_in];
                            end
                        end
                        ST_STATUS_READ_CMD: begin
                            if (cnt_q[2:0] == `BYTE_LAST) begin
                                cnt_d = 6'h00;
                                out_d = stat_byte;
                            end
                        end
                        ST_STATUS_WRITE_CMD: begin
                            if (cnt_q[2:0] == `BYTE_LAST) begin
                                st_d = ST_IGN;
                                if (wel_q && !(stat_q[`STAT_PEN_BIT]
                                    && !wp_n_s)) begin
                                    stat_d = op_in[7:2];
                                end
                            end
                        end
                        ST_READ: begin
                            if (cnt_q[2:0] == `BYTE_LAST) begin
                                cnt_d = 6'h00;
                                addr_d = addr_q + 15'h0001;
                                out_d = mem[addr_q + 15'h0001];
                            end
                        end
                        ST_WRITE: begin
                            if (cnt_q[2:0] == `BYTE_LAST) begin
                                cnt_d = 6'h00;
                                mem_we = wel_q
                                    && !is_prot(stat_q[1:0], addr_q);
                                addr_d = addr_q + 15'h0001;
                            end
                        end
                        ST_IDENT_READ_CMD: begin
                            if (cnt_q == `ID_DONE) begin
                                cnt_d = cnt_q;
                            end else if (cnt_q[2:0] == `BYTE_LAST
                                && cnt_q != `ID_LAST) begin
                                out_d = id_byte(2'(cnt_q[4:3] + 2'h1));
                            end
                        end
                        ST_ARM: st_d = ST_IGN;
                        default: st_d = ST_IGN;
                    endcase
                end
            end
        endcase
        oe_d = cs_low && !hold_act
            && (st_d == ST_STATUS_READ_CMD || st_d == ST_READ || st_d == ST_IDENT_READ_CMD);
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_q <= ST_CMD;
            cnt_q <= 6'h00;
            sh_q <= 8'h00;
            out_q <= 8'h00;
            so_q <= 1'b0;
            oe_q <= 1'b0;
            addr_q <= 15'h0000;
            wel_q <= 1'b0;
            clrw_q <= 1'b0;
            wr_q <= 1'b0;
            stat_q <= `STAT_NV_RST;
            wake_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            out_q <= out_d;
            so_q <= so_d;
            oe_q <= oe_d;
            addr_q <= addr_d;
            wel_q <= wel_d;
            clrw_q <= clrw_d;
            wr_q <= wr_d;
            stat_q <= stat_d;
            wake_q <= wake_d;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (mem_we) begin
            mem[addr_q] <= op_in;
        end
    end

    assign o_so = so_q;
    assign o_so_oe = oe_q;
    assign o_sleep = (st_q == ST_SLEEP) || (st_q == ST_WAKE);
    assign o_status = stat_byte;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    logic op_done;
    assign op_done = st_q == ST_CMD && rise && cnt_q[2:0] == `BYTE_LAST;

    a_latch_clear: assert property (
        op_done && op_in == `OP_LATCH_CLR |=> !wel_q [*3])
        else $error("latch not cleared by clear command");
    a_latch_set: assert property (
        op_done && op_in == `OP_LATCH_SET |=> wel_q)
        else $error("latch not set by set command");
    a_stat_guard: assert property (
        st_q == ST_STATUS_WRITE_CMD && !wel_q |=> $stable(stat_q))
        else $error("status written with latch clear");
    a_bit_zero: assert property (o_status[0] == 1'b0)
        else $error("status bit zero not zero");
    a_sleep_float: assert property (
        st_q == ST_SLEEP |=> !o_so_oe)
        else $error("output driven while sleeping");
    a_hold_float: assert property (
        hold_act |=> !o_so_oe)
        else $error("output driven during hold");
    a_read_wrap: assert property (
        st_q == ST_READ && rise && cnt_q[2:0] == `BYTE_LAST
        && addr_q == 15'h7fff |=> addr_q == 15'h0000)
        else $error("read address did not wrap");
    a_prot_write: assert property (
        mem_we |-> wel_q && stat_q[1:0] != 2'h3
        && !(stat_q[1] && addr_q >= 15'h4000)
        && !(stat_q[0] && addr_q >= 15'h6000))
        else $error("write into protected block");
    a_sleep_cancel: assert property (
        st_q == ST_ARM && rise |=> st_q == ST_IGN)
        else $error("sleep not cancelled by clock");
    a_wake_latch: assert property (
        st_q == ST_WAKE && st_d == ST_CMD |=> !wel_q && !o_sleep)
        else $error("wake did not clear latch");
    a_id_hold: assert property (
        st_q == ST_IDENT_READ_CMD && cnt_q == `ID_DONE && !cs_rise
        |=> $stable(o_so))
        else $error("id output moved after last bit");

    c_mem_write: cover property (mem_we);
    c_read_wrap: cover property (st_q == ST_READ && addr_q == 15'h7fff);
    c_sleep_wake: cover property (st_q == ST_WAKE ##1 st_q == ST_CMD);
    c_id_done: cover property (st_q == ST_IDENT_READ_CMD && cnt_q == `ID_DONE);
endmodule // spi_nv_mem

/* sim/spi_master_model.sv */
// behavioural spi master in mode 0 driving the memory pins
`timescale 1ns/10ps
module spi_master_model (
    input wire logic i_clk_sys,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si,
    output logic o_hold_n
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_hold_n = 1'b1;
    end
    // step n system clocks, land just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic sel(input logic lvl);
        o_cs_n = lvl;
        tick(6);
    endtask
    // msb first, so taken at the rising edge, undriven so reads x
    task automatic shift(input logic [7:0] tx, input int n,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            o_si = tx[i];
            tick(4);
            rx = {rx[6:0], i_so_oe ? i_so : 1'bx};
            o_sck = 1'b1;
            tick(4);
            o_sck = 1'b0;
        end
    endtask
    // hold entered and left with sck low, one stray clock inside
    // the last sck fall is let through before hold moves
    task automatic hold(input logic lvl);
        tick(4);
        o_hold_n = lvl;
        tick(4);
        if (!lvl) begin
            o_sck = 1'b1;
            tick(4);
            o_sck = 1'b0;
            tick(4);
        end
    endtask
endmodule // spi_master_model

/* sim/testbench.sv */
// self-checking bench for the serial nonvolatile memory
`timescale 1ns/10ps
`include "spi_nv_defs.svh"
module testbench;
    localparam int unsigned WAKE = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic cs_n, sck, si, hold_n, so, so_oe, sleep;
    logic [7:0] status, rx;
    logic [1:0] bp_cur = 2'h0;
    logic [7:0] ref_mem [int];
    logic [7:0] txq [$];
    logic [7:0] rxq [$];
    int fails = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    spi_master_model master_u (.i_clk_sys(clk), .i_so(so),
        .i_so_oe(so_oe), .o_cs_n(cs_n), .o_sck(sck), .o_si(si),
        .o_hold_n(hold_n));
    // identifier values are arbitrary
    spi_nv_mem #(.WAKE_CYCLES(WAKE), .ID_MAKER(8'hc3), .ID_CONT(8'h7f),
        .ID_PROD0(8'h21), .ID_PROD1(8'h43)) dut_u (.i_clk_sys(clk),
        .i_rst(rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
        .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe),
        .o_sleep(sleep), .o_status(status));
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    function automatic bit is_prot(input logic [1:0] bp,
                                   input logic [14:0] a);
        case (bp)
            2'h0: return 1'b0;
            2'h1: return a >= 15'h6000;
            2'h2: return a >= 15'h4000;
            default: return 1'b1;
        endcase
    endfunction
    // one frame: opcode, optional address, n data bytes each way
    task automatic cmd(input logic [7:0] op, input bit with_addr,
                       input logic [15:0] a, input int n);
        master_u.sel(1'b0);
        master_u.shift(op, 8, rx);
        if (with_addr) begin
            master_u.shift(a[15:8], 8, rx);
            master_u.shift(a[7:0], 8, rx);
        end
        rxq = {};
        for (int i = 0; i < n; i++) begin
            master_u.shift(i < txq.size() ? txq[i] : 8'($urandom), 8, rx);
            rxq.push_back(rx);
        end
        master_u.sel(1'b1);
        txq = {};
    endtask
    task automatic wr_stat(input logic [7:0] v);
        cmd(`OP_LATCH_SET, 1'b0, 16'h0, 0);
        txq = {v};
        cmd(`OP_STAT_WR, 1'b0, 16'h0, 1);
    endtask
    task automatic wr_mem(input logic [15:0] a, input int n);
        logic [14:0] p;
        cmd(`OP_LATCH_SET, 1'b0, 16'h0, 0);
        for (int i = 0; i < n; i++) begin
            p = a[14:0] + i[14:0];
            txq.push_back(8'($urandom));
            if (!is_prot(bp_cur, p))
                ref_mem[p] = txq[i];
        end
        cmd(`OP_MEM_WR, 1'b1, a, n);
    endtask
    task automatic rd_mem(input logic [15:0] a, input int n);
        logic [14:0] p;
        cmd(`OP_MEM_RD, 1'b1, a, n);
        for (int i = 0; i < n; i++) begin
            p = a[14:0] + i[14:0];
            check("mem byte", rxq[i], ref_mem[p]);
        end
    endtask
    initial begin
        logic [7:0] v;
        logic [15:0] a;
        logic [15:0] tgt [4];
        logic [7:0] id_exp [6];
        int n;
        tgt = '{16'h3fff, 16'h5fff, 16'h6000, 16'h7fff};
        id_exp = '{8'hc3, 8'h7f, 8'h21, 8'h43, 8'hff, 8'hff};
        void'($urandom(88));
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        master_u.tick(4);
        check("reset status", status, 8'h00);
        check("reset oe", so_oe, 1'b0);
        cmd(`OP_LATCH_SET, 1'b0, 16'h0, 0);
        check("latch set", status[1], 1'b1);
        cmd(`OP_LATCH_CLR, 1'b0, 16'h0, 0);
        check("latch clear", status[1], 1'b0);
        txq = {8'hfc};
        cmd(`OP_STAT_WR, 1'b0, 16'h0, 1);
        check("locked status", status, 8'h00);
        v = (8'($urandom) & 8'h70) | 8'h03;
        wr_stat(v);
        check("status write", status, {v[7:2], 2'b00});
        cmd(`OP_STAT_RD, 1'b0, 16'h0, 2);
        check("status rd", rxq[0], {v[7:2], 2'b00});
        check("status again", rxq[1], {v[7:2], 2'b00});
        $display("test status done");
        wr_mem(16'hfffe, 3);
        check("write latch", status[1], 1'b0);
        rd_mem(16'hfffe, 3);
        for (int k = 0; k < 4; k++) begin
            a = 16'($urandom);
            n = 1 + ($urandom % 4);
            wr_mem(a, n);
            rd_mem(a, n);
        end
        txq = {~ref_mem[15'h7fff]};
        cmd(`OP_MEM_WR, 1'b1, 16'h7fff, 1);
        rd_mem(16'h7fff, 1);
        $display("test memory done");
        for (int b = 0; b < 4; b++) begin
            wp_n = 1'($urandom);
            wr_stat({4'h0, b[1:0], 2'b00});
            bp_cur = b[1:0];
            foreach (tgt[k]) wr_mem(tgt[k], 1);
            foreach (tgt[k]) rd_mem(tgt[k], 1);
        end
        wr_stat(8'h80);
        wp_n = 1'b0;
        wr_stat(8'h8c);
        check("pen locked", status, 8'h80);
        wp_n = 1'b1;
        wr_stat(8'h00);
        check("pen open", status, 8'h00);
        bp_cur = 2'h0;
        $display("test protect done");
        cmd(`OP_ID_RD, 1'b0, 16'h0, 6);
        foreach (id_exp[k]) check("id byte", rxq[k], id_exp[k]);
        $display("test ident done");
        master_u.sel(1'b0);
        master_u.shift(`OP_MEM_RD, 8, rx);
        master_u.shift(8'h7f, 8, rx);
        master_u.shift(8'hff, 8, rx);
        master_u.shift(8'h00, 4, rx);
        master_u.hold(1'b0);
        check("hold float", so_oe, 1'b0);
        master_u.hold(1'b1);
        master_u.shift(8'h00, 4, v);
        master_u.sel(1'b1);
        check("hold byte", {rx[3:0], v[3:0]}, ref_mem[15'h7fff]);
        cmd(`OP_LATCH_SET, 1'b0, 16'h0, 0);
        master_u.sel(1'b0);
        master_u.shift(`OP_LATCH_CLR, 4, rx);
        master_u.hold(1'b0);
        master_u.sel(1'b1);
        master_u.hold(1'b1);
        check("hold abort", status[1], 1'b1);
        $display("test hold done");
        master_u.sel(1'b0);
        master_u.shift(`OP_SLEEP, 8, rx);
        master_u.shift(8'h00, 1, rx);
        master_u.sel(1'b1);
        check("sleep cancel", sleep, 1'b0);
        cmd(`OP_SLEEP, 1'b0, 16'h0, 0);
        check("sleep entry", sleep, 1'b1);
        check("sleep float", so_oe, 1'b0);
        master_u.sel(1'b0);
        master_u.sel(1'b1);
        n = 12;
        while (sleep === 1'b1 && n < WAKE + 40) begin
            master_u.tick(1);
            n++;
        end
        check("wake time", n >= WAKE && n <= WAKE + 8, 1'b1);
        check("wake latch", status[1], 1'b0);
        cmd(`OP_STAT_RD, 1'b0, 16'h0, 1);
        check("awake status", rxq[0], 8'h00);
        $display("test sleep done");
        close_out();
    end
    initial begin
        #400000;
        fails++;
        close_out();
    end
endmodule // testbench
